// ===== core/irq_pkg.sv
// Purpose: shared constants and types for the interrupt priority block
// Assumes: avalon-mm byte addresses, one 32-bit word per register
// Notes:   8-bit registers sit in the low byte, upper bits read as zero
package irq_pkg;
	// ****************************************
	// bus
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [DATA_W-1:0] writedata;
		logic [3:0]        byteenable;
	} avl_req_s;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFF_MAIN_CTL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SECOND_CTL = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_THIRD_CTL  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PRIO_B     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_CAN_PRIO   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_TMR_LOW    = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_TMR_HIGH   = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_TMR_CTL    = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_SHADOW     = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_STACK_PTR  = 8'h24;

	// ****************************************
	// writable masks and reset values
	// ****************************************
	localparam logic [7:0] MAIN_MASK    = 8'hf7;
	localparam logic [7:0] SECOND_MASK  = 8'hf7;
	localparam logic [7:0] THIRD_MASK   = 8'hff;
	localparam logic [7:0] PRIO_B_MASK  = 8'h4f;
	localparam logic [7:0] TMR_CTL_MASK = 8'h03;
	localparam logic [7:0] MAIN_RST     = 8'h00;
	localparam logic [7:0] SECOND_RST   = 8'hf7;
	localparam logic [7:0] THIRD_RST    = 8'hc0;
	localparam logic [7:0] PRIO_B_RST   = 8'h4f;
	localparam logic [7:0] CAN_PRIO_RST = 8'hff;
	localparam logic [7:0] TMR_CTL_RST  = 8'h00;
	localparam logic [7:0] BYTE_MAX     = 8'hff;

	// ****************************************
	// field positions
	// ****************************************
	localparam int MAIN_GIE       = 7;
	localparam int MAIN_TMR_EN    = 6;
	localparam int MAIN_EXT0_EN   = 5;
	localparam int MAIN_PB_EN     = 4;
	localparam int MAIN_TMR_FLAG  = 2;
	localparam int MAIN_EXT0_FLAG = 1;
	localparam int MAIN_PB_FLAG   = 0;
	localparam int SEC_EDGE_LSB   = 4;
	localparam int SEC_TMR_PRIO   = 2;
	localparam int SEC_EXT2_PRIO  = 1;
	localparam int SEC_PB_PRIO    = 0;
	localparam int THR_EXT1_PRIO  = 7;
	localparam int THR_EXT3_PRIO  = 6;
	localparam int THR_EN_LSB     = 3;
	localparam int THR_FLAG_LSB   = 0;
	localparam int TCTL_SIXTEEN   = 0;
	localparam int TCTL_RUN       = 1;

	// ****************************************
	// core context
	// ****************************************
	localparam int PC_W = 21;

	typedef struct packed {
		logic [7:0] bank_select_register;
		logic [7:0] status;
		logic [7:0] working_register;
	} core_ctx_s;
endpackage

// ===== core/irq_priority_core.sv
// Purpose: interrupt flags, enables, priorities, timer0 and context save
// Assumes: pins are asynchronous; core side signals share I_CLK
// Notes:   one-cycle wait state on every bus access
`timescale 1ns/10ps
module irq_priority_core #(
	parameter int STACK_DEPTH = 31
) (
	input  wire logic                       I_CLK,
	input  wire logic                       I_SYS_RST,
	input  wire irq_pkg::avl_req_s          I_AVL,
	output logic [irq_pkg::DATA_W-1:0]      O_READDATA,
	output logic                            O_WAITREQUEST,
	input  wire logic [3:0]                 I_EXT_PIN,
	input  wire logic [3:0]                 I_PORTB_HI,
	input  wire logic [4:0]                 I_PERIPH_PEND,
	input  wire logic [7:0]                 I_CAN_PEND,
	input  wire logic                       I_SLEEP,
	input  wire logic                       I_IRQ_ENTRY,
	input  wire logic                       I_STACK_POP,
	input  wire logic [irq_pkg::PC_W-1:0]   I_RETURN_PC,
	input  wire irq_pkg::core_ctx_s         I_CORE_CTX,
	output logic                            O_IRQ_HIGH,
	output logic                            O_IRQ_LOW,
	output logic                            O_WAKE,
	output logic [irq_pkg::PC_W-1:0]        O_STACK_TOP,
	output irq_pkg::core_ctx_s              O_FAST_CTX
);
	import irq_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH + 1);
	localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);
	localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);

	// ****************************************
	// bus slave
	// ****************************************
	logic       wait_reg;
	logic [7:0] main_reg, second_reg, third_reg, prio_b_reg, can_prio_reg;
	logic [7:0] tmr_lo_reg, tmr_hi_reg, tmr_ctl_reg;
	logic [SP_W-1:0] sp_reg;
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];

	wire req     = I_AVL.read | I_AVL.write;
	wire acc_go  = req & ~wait_reg;
	wire wr_go   = acc_go & I_AVL.write & I_AVL.byteenable[0];
	wire rd_take = I_AVL.read & wait_reg;
	wire [7:0] wdata = I_AVL.writedata[7:0];

	wire wr_main   = wr_go & (I_AVL.address == OFF_MAIN_CTL);
	wire wr_second = wr_go & (I_AVL.address == OFF_SECOND_CTL);
	wire wr_third  = wr_go & (I_AVL.address == OFF_THIRD_CTL);
	wire wr_prio_b = wr_go & (I_AVL.address == OFF_PRIO_B);
	wire wr_can    = wr_go & (I_AVL.address == OFF_CAN_PRIO);
	wire wr_tlo    = wr_go & (I_AVL.address == OFF_TMR_LOW);
	wire wr_thi    = wr_go & (I_AVL.address == OFF_TMR_HIGH);
	wire wr_tctl   = wr_go & (I_AVL.address == OFF_TMR_CTL);

	logic [7:0] rd_byte;
	always_comb begin
		unique case (I_AVL.address)
			OFF_MAIN_CTL:   rd_byte = main_reg;
			OFF_SECOND_CTL: rd_byte = second_reg;
			OFF_THIRD_CTL:  rd_byte = third_reg;
			OFF_PRIO_B:     rd_byte = prio_b_reg & PRIO_B_MASK;
			OFF_CAN_PRIO:   rd_byte = can_prio_reg;
			OFF_TMR_LOW:    rd_byte = tmr_lo_reg;
			OFF_TMR_HIGH:   rd_byte = tmr_hi_reg;
			OFF_TMR_CTL:    rd_byte = tmr_ctl_reg;
			default:        rd_byte = 8'h00;
		endcase
	end

	// shadow word is wider than a byte, so it bypasses the byte mux
	wire rd_shadow = (I_AVL.address == OFF_SHADOW);
	wire rd_sp     = (I_AVL.address == OFF_STACK_PTR);
	wire [DATA_W-1:0] rd_word = rd_shadow ? {8'h00, O_FAST_CTX} :
		rd_sp ? {{(DATA_W-SP_W){1'b0}}, sp_reg} : {24'h000000, rd_byte};

	// waitrequest idles high; drops for exactly one cycle per access
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			wait_reg   <= 1'b1;
			O_READDATA <= '0;
		end else begin
			wait_reg <= ~(req & wait_reg);
			if (rd_take) begin
				O_READDATA <= rd_word;
			end
		end
	end
	assign O_WAITREQUEST = wait_reg;

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	logic [3:0] ext_s1, ext_s2, ext_p;
	logic [3:0] pb_s1, pb_s2, pb_p;

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			ext_s1 <= 4'h0;
			ext_s2 <= 4'h0;
			ext_p  <= 4'h0;
			pb_s1  <= 4'h0;
			pb_s2  <= 4'h0;
			pb_p   <= 4'h0;
		end else begin
			ext_s1 <= I_EXT_PIN;
			ext_s2 <= ext_s1;
			ext_p  <= ext_s2;
			pb_s1  <= I_PORTB_HI;
			pb_s2  <= pb_s1;
			pb_p   <= pb_s2;
		end
	end

	wire [3:0] edge_sel = second_reg[SEC_EDGE_LSB +: 4];
	wire [3:0] ext_rise = ext_s2 & ~ext_p;
	wire [3:0] ext_fall = ~ext_s2 & ext_p;
	wire [3:0] ext_set  = (edge_sel & ext_rise) | (~edge_sel & ext_fall);
	// any toggle counts, so a glitch pair also sets the flag
	wire       pb_change = |(pb_s2 ^ pb_p);

	// ****************************************
	// timer0
	// ****************************************
	wire        tmr_run  = tmr_ctl_reg[TCTL_RUN];
	wire        tmr_16   = tmr_ctl_reg[TCTL_SIXTEEN];
	wire [15:0] tmr_pair = {tmr_hi_reg, tmr_lo_reg};
	wire        lo_wrap  = tmr_run & (tmr_lo_reg == BYTE_MAX);
	wire        tmr_ovf  = tmr_16 ? (lo_wrap & (tmr_hi_reg == BYTE_MAX))
		: lo_wrap;
	wire [15:0] pair_inc = tmr_pair + 16'h0001;
	wire [7:0]  lo_next  = wr_tlo ? wdata : (tmr_run ? pair_inc[7:0] : tmr_lo_reg);
	wire [7:0]  hi_next  = wr_thi ? wdata :
		((tmr_run & tmr_16) ? pair_inc[15:8] : tmr_hi_reg);

	// ****************************************
	// control registers; hardware set wins over a same-cycle clear
	// ****************************************
	wire [7:0] main_set  = {5'h00, tmr_ovf, ext_set[0], pb_change};
	wire [7:0] third_set = {5'h00, ext_set[3:1]};
	// flags are only cleared by a bus write, never by the hardware
	wire [7:0] main_next  = (wr_main ? (wdata & MAIN_MASK) : main_reg) | main_set;
	wire [7:0] third_next = (wr_third ? wdata : third_reg) | third_set;

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			main_reg     <= MAIN_RST;
			second_reg   <= SECOND_RST;
			third_reg    <= THIRD_RST;
			prio_b_reg   <= PRIO_B_RST;
			can_prio_reg <= CAN_PRIO_RST;
			tmr_ctl_reg  <= TMR_CTL_RST;
			tmr_lo_reg   <= 8'h00;
			tmr_hi_reg   <= 8'h00;
		end else begin
			main_reg   <= main_next;
			third_reg  <= third_next;
			tmr_lo_reg <= lo_next;
			tmr_hi_reg <= hi_next;
			if (wr_second) begin
				second_reg <= wdata & SECOND_MASK;
			end
			if (wr_prio_b) begin
				prio_b_reg <= wdata & PRIO_B_MASK;
			end
			if (wr_can) begin
				can_prio_reg <= wdata;
			end
			if (wr_tctl) begin
				tmr_ctl_reg <= wdata & TMR_CTL_MASK;
			end
		end
	end

	// ****************************************
	// pending sources and priority routing
	// ****************************************
	wire       gie      = main_reg[MAIN_GIE];
	wire [3:0] ext_flag = {third_reg[THR_FLAG_LSB +: 3], main_reg[MAIN_EXT0_FLAG]};
	wire [3:0] ext_en   = {third_reg[THR_EN_LSB +: 3], main_reg[MAIN_EXT0_EN]};
	wire [3:0] ext_pend = ext_flag & ext_en;
	wire tmr_pend = main_reg[MAIN_TMR_FLAG] & main_reg[MAIN_TMR_EN];
	wire pb_pend  = main_reg[MAIN_PB_FLAG] & main_reg[MAIN_PB_EN];

	// ext0 carries a constant one: it has no selectable level
	wire [3:0] ext_prio = {third_reg[THR_EXT3_PRIO], second_reg[SEC_EXT2_PRIO],
		third_reg[THR_EXT1_PRIO], 1'b1};
	wire [4:0] periph_prio = {prio_b_reg[6], prio_b_reg[3], prio_b_reg[2],
		prio_b_reg[1], prio_b_reg[0]};
	wire [18:0] pend_vec = {ext_pend, tmr_pend, pb_pend, I_PERIPH_PEND, I_CAN_PEND};
	wire [18:0] prio_vec = {ext_prio, second_reg[SEC_TMR_PRIO], second_reg[SEC_PB_PRIO],
		periph_prio, can_prio_reg};
	wire high_next = gie & |(pend_vec & prio_vec);
	wire low_next  = gie & |(pend_vec & ~prio_vec);

	// ****************************************
	// sleep wake
	// ****************************************
	logic       sleep_p;
	logic [3:0] wake_en_reg;
	// enables are frozen at sleep entry; later changes do not arm a wake
	wire        sleep_rise = I_SLEEP & ~sleep_p;
	wire        wake_next  = I_SLEEP & |(ext_flag & wake_en_reg);

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			sleep_p     <= 1'b0;
			wake_en_reg <= 4'h0;
			O_IRQ_HIGH  <= 1'b0;
			O_IRQ_LOW   <= 1'b0;
			O_WAKE      <= 1'b0;
		end else begin
			sleep_p    <= I_SLEEP;
			O_IRQ_HIGH <= high_next;
			O_IRQ_LOW  <= low_next;
			O_WAKE     <= wake_next;
			if (sleep_rise) begin
				wake_en_reg <= ext_en;
			end
		end
	end

	// ****************************************
	// return stack and fast shadow
	// ****************************************
	wire push = I_IRQ_ENTRY & (sp_reg != SP_FULL);
	// push wins over a pop in the same cycle; a pop on empty is dropped
	wire pop  = I_STACK_POP & ~I_IRQ_ENTRY & (sp_reg != '0);
	wire [SP_W-1:0] sp_dec = sp_reg - SP_ONE;
	wire [SP_W-1:0] sp_under = sp_dec - SP_ONE;
	wire [PC_W-1:0] below_top = (sp_dec == '0) ? '0 : stack_mem[sp_under];

	always_ff @(posedge I_CLK) begin
		if (push) begin
			stack_mem[sp_reg] <= I_RETURN_PC;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			sp_reg      <= '0;
			O_STACK_TOP <= '0;
			O_FAST_CTX  <= '0;
		end else begin
			if (push) begin
				sp_reg      <= sp_reg + SP_ONE;
				O_STACK_TOP <= I_RETURN_PC;
			end else if (pop) begin
				sp_reg      <= sp_dec;
				O_STACK_TOP <= below_top;
			end
			if (I_IRQ_ENTRY) begin
				O_FAST_CTX <= I_CORE_CTX;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_prio_b_reserved: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(rd_take && I_AVL.address == OFF_PRIO_B)
		|=> (O_READDATA[7] == 1'b0 && O_READDATA[5:4] == 2'b00))
		else $error("reserved priority bits read nonzero");

	a_ext_rise_flag: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(edge_sel[0] && $rose(ext_s2[0])) |=> main_reg[MAIN_EXT0_FLAG])
		else $error("rising edge did not set external flag");

	a_ext_fall_flag: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(!edge_sel[3] && $fell(ext_s2[3]) && !wr_second) |=> third_reg[2])
		else $error("falling edge did not set external flag");

	a_idle_no_req: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(pend_vec == '0) |=> (!O_IRQ_HIGH && !O_IRQ_LOW))
		else $error("request raised with nothing pending");

	a_ext0_always_high: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(gie && ext_pend[0]) |=> O_IRQ_HIGH)
		else $error("external zero not routed high");

	a_tmr_wrap8: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(tmr_run && !tmr_16 && tmr_lo_reg == 8'hff && !wr_tlo)
		|=> (tmr_lo_reg == 8'h00 && main_reg[MAIN_TMR_FLAG]))
		else $error("8-bit wrap did not set timer flag");

	a_tmr_wrap16: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(tmr_run && tmr_16 && tmr_pair == 16'hfffe && !wr_tlo && !wr_thi)
		##1 (tmr_run && tmr_16 && !wr_tlo && !wr_thi)
		|=> (tmr_pair == 16'h0000 && main_reg[MAIN_TMR_FLAG]))
		else $error("16-bit wrap did not set timer flag");

	a_port_change: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		$changed(pb_s2) |=> main_reg[MAIN_PB_FLAG])
		else $error("port change missed");

	a_wake_sleep: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_SLEEP && |(ext_flag & wake_en_reg)) |=> O_WAKE)
		else $error("armed external flag did not wake");

	a_stack_push: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		push |=> (O_STACK_TOP == $past(I_RETURN_PC) && sp_reg == $past(sp_reg) + SP_ONE))
		else $error("return address not pushed");

	a_shadow_save: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		I_IRQ_ENTRY |=> (O_FAST_CTX == $past(I_CORE_CTX)))
		else $error("context not shadowed on entry");

	// routing checks: can sources at both levels, peripherals and port change high only, timer and ext2 low only
	a_gie_blocks_req: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!gie |=> (!O_IRQ_HIGH && !O_IRQ_LOW))
		else $error("request raised with global enable off");

	a_can_high_route: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(gie && |(I_CAN_PEND & can_prio_reg)) |=> O_IRQ_HIGH)
		else $error("high priority can source not routed high");

	a_can_low_route: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(gie && |(I_CAN_PEND & ~can_prio_reg)) |=> O_IRQ_LOW)
		else $error("low priority can source not routed low");

	a_periph_high_route: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(gie && |(I_PERIPH_PEND & periph_prio)) |=> O_IRQ_HIGH)
		else $error("high priority peripheral not routed high");

	a_tmr_low_route: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(gie && tmr_pend && !second_reg[SEC_TMR_PRIO]) |=> O_IRQ_LOW)
		else $error("low priority timer not routed low");

	a_pb_high_route: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(gie && pb_pend && second_reg[SEC_PB_PRIO]) |=> O_IRQ_HIGH)
		else $error("high priority port change not routed high");

	a_ext2_low_route: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(gie && ext_pend[2] && !second_reg[SEC_EXT2_PRIO]) |=> O_IRQ_LOW)
		else $error("low priority external two not routed low");
endmodule

// ===== verification/irq_core_model.sv
// Purpose: core side model that takes requests and returns from them
// Assumes: shares I_CLK with the interrupt block
// Notes:   at most one entry per one-cycle take pulse from the bench
`timescale 1ns/10ps
module irq_core_model (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_req,
	input  wire logic               i_take,
	input  wire logic               i_ret,
	input  wire irq_pkg::core_ctx_s i_ctx,
	output logic                    o_entry,
	output logic                    o_pop,
	output irq_pkg::core_ctx_s      o_saved
);
	import irq_pkg::*;
	// ****************************************
	// entry and return
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_entry <= 1'b0;
			o_pop   <= 1'b0;
			o_saved <= '0;
		end else begin
			// only enter while a request really stands
			o_entry <= i_take & i_req;
			o_pop   <= i_ret;
			if (i_take & i_req) begin
				o_saved <= i_ctx; // software copy when fast return unused
			end
		end
	end
endmodule

// ===== verification/interrupt_priority_and_sources_bench.sv
// Purpose: self-checking bench for the interrupt priority block
// Assumes: one wait state per access, pins synchronised by two flops
// Notes:   expectations come from a register model kept in the bench
`timescale 1ns/10ps
module interrupt_priority_and_sources_bench;
	import irq_pkg::*;
	logic            clk, rst, slp, take, ret, entry, pop, irq_h, irq_l, wake, wreq;
	logic [3:0]      ext, pb;
	logic [4:0]      pper;
	logic [7:0]      pcan, mm, ms, mt, mp, mc, v;
	logic [31:0]     rdata, q, seed;
	logic [PC_W-1:0] pc, top;
	core_ctx_s       ctx, fctx, saved, ec;
	avl_req_s        avl;
	logic [PC_W-1:0] stk[$];
	int              bad_count = 0;
	int              total_checks = 0;
	int              cyc = 0;

	irq_priority_core i_dut (
		.I_CLK(clk), .I_SYS_RST(rst), .I_AVL(avl), .O_READDATA(rdata),
		.O_WAITREQUEST(wreq), .I_EXT_PIN(ext), .I_PORTB_HI(pb), .I_PERIPH_PEND(pper),
		.I_CAN_PEND(pcan), .I_SLEEP(slp), .I_IRQ_ENTRY(entry), .I_STACK_POP(pop),
		.I_RETURN_PC(pc), .I_CORE_CTX(ctx), .O_IRQ_HIGH(irq_h), .O_IRQ_LOW(irq_l),
		.O_WAKE(wake), .O_STACK_TOP(top), .O_FAST_CTX(fctx));
	irq_core_model i_core (.i_clk(clk), .i_rst(rst), .i_req(irq_h | irq_l), .i_take(take),
		.i_ret(ret), .i_ctx(ctx), .o_entry(entry), .o_pop(pop), .o_saved(saved));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ****************************************
	// hang guard
	// ****************************************
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	// ****************************************
	// model and helpers
	// ****************************************
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] exp_reg(input logic [7:0] a);
		case (a)
			OFF_MAIN_CTL:   return {24'h0, mm};
			OFF_SECOND_CTL: return {24'h0, ms};
			OFF_THIRD_CTL:  return {24'h0, mt};
			OFF_PRIO_B:     return {24'h0, mp};
			OFF_CAN_PRIO:   return {24'h0, mc};
			default:        return 32'h0;
		endcase
	endfunction
	function automatic logic [1:0] exp_irq();
		logic [18:0] p, r;
		p = {mm[2] & mm[6], mm[1] & mm[5], mm[0] & mm[4], mt[0] & mt[3], mt[1] & mt[4],
			mt[2] & mt[5], pper, pcan};
		r = {ms[2], 1'b1, ms[0], mt[7], ms[1], mt[6], mp[6], mp[3:0], mc};
		return mm[7] ? {|(p & r), |(p & ~r)} : 2'b00;
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
		avl.address <= a;
		avl.read <= ~wr;
		avl.write <= wr;
		avl.writedata <= {24'h0, d};
		@(posedge clk);
		while (wreq !== 1'b0) begin
			@(posedge clk);
		end
		q = rdata;
		avl.read <= 1'b0;
		avl.write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
		case (a)
			OFF_MAIN_CTL:   mm = d & MAIN_MASK;
			OFF_SECOND_CTL: ms = d & SECOND_MASK;
			OFF_THIRD_CTL:  mt = d & THIRD_MASK;
			OFF_PRIO_B:     mp = d & PRIO_B_MASK;
			OFF_CAN_PRIO:   mc = d;
			default:        ;
		endcase
	endtask
	task automatic rd(input logic [7:0] a);
		bus(a, 1'b0, 8'h00);
		cmp(q, exp_reg(a));
	endtask
	task automatic irqc();
		repeat (3) @(posedge clk);
		cmp({30'h0, irq_h, irq_l}, {30'h0, exp_irq()});
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		avl = '0;
		avl.byteenable = 4'hf;
		{ext, pb, pper, pcan, slp, take, ret, pc, ctx} = '0;
		seed = 32'h7704;
		{mm, ms, mt, mp, mc} = {MAIN_RST, SECOND_RST, THIRD_RST, PRIO_B_RST, CAN_PRIO_RST};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a <= 'h2c; a += 4) rd(8'(a));
		wr(OFF_PRIO_B, 8'hff);
		rd(OFF_PRIO_B);
		wr(8'h2c, 8'h55);
		rd(8'h2c);
		wr(OFF_MAIN_CTL, 8'h80);
		for (int k = 0; k < 12; k++) begin
			seed = nxt(seed);
			wr(OFF_PRIO_B, seed[7:0]);
			wr(OFF_CAN_PRIO, seed[15:8]);
			rd(OFF_CAN_PRIO);
			pper <= seed[20:16];
			pcan <= seed[31:24];
			irqc();
		end
		// a write with the low byte lane off must be ignored
		avl.byteenable <= 4'he;
		bus(OFF_CAN_PRIO, 1'b1, ~mc);
		avl.byteenable <= 4'hf;
		rd(OFF_CAN_PRIO);
		wr(OFF_MAIN_CTL, 8'h00);
		irqc();
		pper <= '0;
		pcan <= '0;
		// edge detection, each pin both polarities, wrong edge first or second
		for (int i = 0; i < 4; i++) begin
			for (int pol = 0; pol < 2; pol++) begin
				v = ms & ~(8'h10 << i);
				wr(OFF_SECOND_CTL, pol ? (v | (8'h10 << i)) : v);
				for (int t = 0; t < 2; t++) begin
					wr(OFF_MAIN_CTL, mm & 8'hfd);
					wr(OFF_THIRD_CTL, mt & 8'hf8);
					ext[i] <= ~ext[i];
					repeat (6) @(posedge clk);
					if (ext[i] == pol[0]) begin
						if (i == 0) mm[1] = 1'b1;
						else mt[i-1] = 1'b1;
					end
					rd(OFF_MAIN_CTL);
					rd(OFF_THIRD_CTL);
				end
			end
		end
		wr(OFF_SECOND_CTL, ms | 8'hf0);
		ext <= 4'hf;
		repeat (6) @(posedge clk);
		mm[1] = 1'b1;
		mt[2:0] = 3'h7;
		for (int k = 0; k < 8; k++) begin
			seed = nxt(seed);
			wr(OFF_MAIN_CTL, {2'b10, seed[5], 5'b00010});
			wr(OFF_SECOND_CTL, {4'hf, 1'b0, seed[2:0]});
			wr(OFF_THIRD_CTL, {seed[4:3], seed[8:6], 3'h7});
			irqc();
		end
		wr(OFF_THIRD_CTL, 8'h38);
		irqc();
		wr(OFF_MAIN_CTL, 8'h00);
		ext <= 4'h0;
		wr(OFF_THIRD_CTL, 8'h08);
		slp <= 1'b1;
		repeat (4) @(posedge clk);
		cmp({31'h0, wake}, 32'h0);
		ext[1] <= 1'b1;
		repeat (6) @(posedge clk);
		cmp({31'h0, wake}, 32'h1);
		slp <= 1'b0;
		mt[0] = 1'b1;
		rd(OFF_THIRD_CTL);
		wr(OFF_THIRD_CTL, 8'h00);
		// timer0 in both widths
		wr(OFF_TMR_LOW, 8'hfe);
		wr(OFF_TMR_CTL, 8'h02);
		repeat (4) @(posedge clk);
		wr(OFF_TMR_CTL, 8'h00);
		mm[2] = 1'b1;
		rd(OFF_MAIN_CTL);
		rd(OFF_TMR_HIGH);
		wr(OFF_MAIN_CTL, 8'hc4);
		irqc();
		wr(OFF_SECOND_CTL, ms ^ 8'h04);
		irqc();
		wr(OFF_MAIN_CTL, 8'h00);
		wr(OFF_TMR_HIGH, 8'hfe);
		wr(OFF_TMR_LOW, 8'hf0);
		wr(OFF_TMR_CTL, 8'h03);
		repeat (30) @(posedge clk);
		rd(OFF_MAIN_CTL);
		repeat (260) @(posedge clk);
		wr(OFF_TMR_CTL, 8'h00);
		mm[2] = 1'b1;
		rd(OFF_MAIN_CTL);
		// port change on every upper pin
		for (int j = 0; j < 4; j++) begin
			wr(OFF_MAIN_CTL, 8'h90);
			pb[j] <= ~pb[j];
			repeat (6) @(posedge clk);
			mm[0] = 1'b1;
			rd(OFF_MAIN_CTL);
			wr(OFF_SECOND_CTL, ms ^ 8'h01);
			irqc();
		end
		// entries back to back, then returns down to empty
		for (int k = 0; k < 3; k++) begin
			seed = nxt(seed);
			pc <= seed[20:0];
			ctx <= seed[31:8];
			ec = seed[31:8];
			stk.push_back(seed[20:0]);
			take <= 1'b1;
			@(posedge clk);
			take <= 1'b0;
			repeat (3) @(posedge clk);
			cmp({11'h0, top}, {11'h0, stk[$]});
			cmp({8'h0, fctx}, {8'h0, ec});
			cmp({8'h0, saved}, {8'h0, ec});
		end
		for (int k = 0; k < 3; k++) begin
			ret <= 1'b1;
			@(posedge clk);
			ret <= 1'b0;
			void'(stk.pop_back());
			repeat (3) @(posedge clk);
			cmp({11'h0, top}, (stk.size() > 0) ? {11'h0, stk[$]} : 32'h0);
		end
		complete_run();
	end
endmodule
